// ===== logic/tcp_pkg.sv
// Purpose: shared constants for the timer, capture and pwm control block
// Assumes: 8-bit register port, 10 MHz core clock
// Notes: offsets are byte indices on the plain register port
package tcp_pkg;
    localparam int unsigned TCP_AW = 4;
    localparam int unsigned TCP_DW = 8;
    // register offsets
    localparam logic [3:0] TCP_OFS_CTRL = 4'h0;
    localparam logic [3:0] TCP_OFS_CA1L = 4'h1;
    localparam logic [3:0] TCP_OFS_CA1H = 4'h2;
    localparam logic [3:0] TCP_OFS_CAPTURE2_LOW_BYTE = 4'h3;
    localparam logic [3:0] TCP_OFS_CAPTURE2_HIGH_BYTE = 4'h4;
    localparam logic [3:0] TCP_OFS_T1 = 4'h5;
    localparam logic [3:0] TCP_OFS_T2 = 4'h6;
    localparam logic [3:0] TCP_OFS_T3L = 4'h7;
    localparam logic [3:0] TCP_OFS_T3H = 4'h8;
    localparam logic [3:0] TCP_OFS_CFG = 4'h9;
    localparam logic [3:0] TCP_OFS_IRQ_STAT = 4'hA;
    localparam logic [3:0] TCP_OFS_IRQ_MASK = 4'hB;
    // status/control field positions
    localparam int unsigned TCP_B_CA2OV = 7;
    localparam int unsigned TCP_B_CA1OV = 6;
    localparam int unsigned TCP_B_PWM2 = 5;
    localparam int unsigned TCP_B_PWM1 = 4;
    localparam int unsigned TCP_B_SEL = 3;
    localparam int unsigned TCP_B_T3RUN = 2;
    localparam int unsigned TCP_B_T2RUN = 1;
    localparam int unsigned TCP_B_T1RUN = 0;
    // config register: cascade select and pin direction bits
    localparam int unsigned TCP_B_CASC = 0;
    localparam int unsigned TCP_B_DIR2 = 1;
    localparam int unsigned TCP_B_DIR3 = 2;
    // interrupt bits: capture1, capture2, overflow1, overflow2
    localparam int unsigned TCP_IRQ_N = 4;
    // writable mask of the status/control register
    localparam logic [7:0] TCP_CTRL_WMASK = 8'h3F;
    localparam logic [7:0] TCP_RST_BYTE = 8'h00;
    localparam logic [15:0] TCP_RST_WORD = 16'h0000;
    localparam logic [2:0] TCP_RST_CFG = 3'h6;
    localparam logic [3:0] TCP_RST_IRQ = 4'h0;
    localparam int unsigned TCP_SYNC_N = 3;
endpackage

// ===== logic/tcp_ctrl.sv
// Purpose: control/status register, capture latching and timer run gating
// Assumes: capture event pins asynchronous; register port on i_ref_clk
// Notes: pwm duty generation lives outside; this block steers pin direction
//
// Implementation choices: the plain strobed port and the register addresses.
module tcp_ctrl (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [tcp_pkg::TCP_AW-1:0] i_addr,
    input wire logic [tcp_pkg::TCP_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [tcp_pkg::TCP_DW-1:0] o_rdata,
    // capture event pins, asynchronous
    input wire logic i_cap1_pin,
    input wire logic i_cap2_pin,
    // pwm drive from the duty logic
    input wire logic i_pwm1_level,
    input wire logic i_pwm2_level,
    // shared pin outputs, enable low while driving
    output logic o_pwm1_shared_pin_oe_n,
    output logic o_pwm2_shared_pin_oe_n,
    output logic o_pwm1_enable,
    output logic o_pwm2_enable,
    // interrupt
    output logic o_irq
);
    import tcp_pkg::*;

    logic [7:0] ctrl;
    logic [2:0] cfg;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic [7:0] t1;
    logic [7:0] t2;
    logic [15:0] t3;
    logic [15:0] next_t3;
    logic [1:0] full;
    logic [1:0] master_ov;
    logic [1:0] rd_lo;
    logic [1:0] rd_hi;
    logic [1:0] both_read;
    logic [1:0] cap_evt;
    logic [1:0] cap_edge;
    logic [1:0] cap_level;
    logic [TCP_SYNC_N-1:0] sync [2];
    logic [TCP_IRQ_N-1:0] irq_stat;
    logic [TCP_IRQ_N-1:0] irq_mask;
    logic [TCP_IRQ_N-1:0] irq_evt;
    logic t1_wrap;

    // three-stage synchroniser per capture pin; only stages 2 and 3 are compared
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    sync[g] <= '0;
                end else begin
                    sync[g] <= {sync[g][TCP_SYNC_N-2:0], (g == 0) ? i_cap1_pin : i_cap2_pin};
                end
            end
            // a change counts once stages 2 and 3 agree
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    cap_level[g] <= 1'b0;
                end else if (sync[g][1] == sync[g][2]) begin
                    cap_level[g] <= sync[g][2];
                end
            end
            assign cap_edge[g] = (sync[g][1] == sync[g][2]) && sync[g][2] && !cap_level[g];
        end
    endgenerate

    // capture1 only exists while the select bit is set
    assign cap_evt[0] = cap_edge[0] && ctrl[TCP_B_SEL];
    assign cap_evt[1] = cap_edge[1];

    // byte read tracking; both_read fires when the pair completes in either order
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || both_read[0]) begin
            rd_lo[0] <= 1'b0;
            rd_hi[0] <= 1'b0;
        end else if (i_rd) begin
            if (i_addr == TCP_OFS_CA1L) rd_lo[0] <= 1'b1;
            if (i_addr == TCP_OFS_CA1H) rd_hi[0] <= 1'b1;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || both_read[1]) begin
            rd_lo[1] <= 1'b0;
            rd_hi[1] <= 1'b0;
        end else if (i_rd) begin
            if (i_addr == TCP_OFS_CAPTURE2_LOW_BYTE) rd_lo[1] <= 1'b1;
            if (i_addr == TCP_OFS_CAPTURE2_HIGH_BYTE) rd_hi[1] <= 1'b1;
        end
    end
    assign both_read[0] = rd_lo[0] && rd_hi[0];
    assign both_read[1] = rd_lo[1] && rd_hi[1];

    // full marks an unread capture; a new event while full is an overflow
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            full <= 2'h0;
            master_ov <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // event wins over the read-clear in the same cycle
                if (cap_evt[i] && full[i] && !both_read[i]) begin
                    master_ov[i] <= 1'b1;
                end else if (both_read[i]) begin
                    master_ov[i] <= cap_evt[i] && full[i];
                end
                if (cap_evt[i]) begin
                    full[i] <= 1'b1;
                end else if (both_read[i]) begin
                    full[i] <= 1'b0;
                end
            end
        end
    end

    // load the capture pair only when empty or fully read in the same cycle, so the oldest unread value survives
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cap1 <= TCP_RST_WORD;
        end else if (i_wr && !ctrl[TCP_B_SEL] && i_addr == TCP_OFS_CA1L) begin
            cap1[7:0] <= i_wdata; // period register write
        end else if (i_wr && !ctrl[TCP_B_SEL] && i_addr == TCP_OFS_CA1H) begin
            cap1[15:8] <= i_wdata;
        end else if (cap_evt[0] && (!full[0] || both_read[0])) begin
            cap1 <= t3;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cap2 <= TCP_RST_WORD;
        end else if (cap_evt[1] && (!full[1] || both_read[1])) begin
            cap2 <= t3;
        end
    end

    // control register: overflow bits are read-only, loaded from the master flags
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ctrl <= TCP_RST_BYTE;
        end else begin
            if (i_wr && i_addr == TCP_OFS_CTRL) begin
                ctrl[5:0] <= i_wdata[5:0] & TCP_CTRL_WMASK[5:0];
            end
            if (both_read[0]) ctrl[TCP_B_CA1OV] <= master_ov[0];
            if (both_read[1]) ctrl[TCP_B_CA2OV] <= master_ov[1];
        end
    end

    // config: cascade select and pin direction bits (1 = input)
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cfg <= TCP_RST_CFG;
        end else if (i_wr && i_addr == TCP_OFS_CFG) begin
            cfg <= i_wdata[2:0];
        end
    end

    // timers 1 and 2; cascade makes t2:t1 one 16-bit counter under run bit 0
    // software must also set timer2 run in cascade
    assign t1_wrap = (t1 == 8'hFF);
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            t1 <= TCP_RST_BYTE;
        end else if (i_wr && i_addr == TCP_OFS_T1) begin
            t1 <= i_wdata;
        end else if (ctrl[TCP_B_T1RUN]) begin
            t1 <= t1 + 8'h01;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            t2 <= TCP_RST_BYTE;
        end else if (i_wr && i_addr == TCP_OFS_T2) begin
            t2 <= i_wdata;
        end else if (ctrl[TCP_B_T2RUN]) begin
            if (!cfg[TCP_B_CASC]) begin
                t2 <= t2 + 8'h01;
            end else if (ctrl[TCP_B_T1RUN] && t1_wrap) begin
                t2 <= t2 + 8'h01;
            end
        end
    end

    // timer3 wraps at the period only when the pair is the period register
    always_comb begin
        next_t3 = t3 + 16'h0001;
        if (!ctrl[TCP_B_SEL] && t3 >= cap1) begin
            next_t3 = TCP_RST_WORD;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            t3 <= TCP_RST_WORD;
        end else if (i_wr && i_addr == TCP_OFS_T3L) begin
            t3[7:0] <= i_wdata;
        end else if (i_wr && i_addr == TCP_OFS_T3H) begin
            t3[15:8] <= i_wdata;
        end else if (ctrl[TCP_B_T3RUN]) begin
            t3 <= next_t3;
        end
    end

    // pwm enable overrides the direction bit; disabled pins follow it
    assign o_pwm1_enable = ctrl[TCP_B_PWM1];
    assign o_pwm2_enable = ctrl[TCP_B_PWM2];
    assign o_pwm1_shared_pin_oe_n = ctrl[TCP_B_PWM1] ? 1'b0 : cfg[TCP_B_DIR2];
    assign o_pwm2_shared_pin_oe_n = ctrl[TCP_B_PWM2] ? 1'b0 : cfg[TCP_B_DIR3];

    // sticky interrupt status, write one to clear, set wins over clear
    assign irq_evt = {
        ctrl[TCP_B_CA2OV] == 1'b0 && both_read[1] && master_ov[1],
        ctrl[TCP_B_CA1OV] == 1'b0 && both_read[0] && master_ov[0],
        cap_evt[1] && !full[1],
        cap_evt[0] && !full[0]
    };
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            irq_stat <= TCP_RST_IRQ;
        end else if (i_wr && i_addr == TCP_OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~i_wdata[TCP_IRQ_N-1:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            irq_mask <= TCP_RST_IRQ;
        end else if (i_wr && i_addr == TCP_OFS_IRQ_MASK) begin
            irq_mask <= i_wdata[TCP_IRQ_N-1:0];
        end
    end
    assign o_irq = |(irq_stat & irq_mask);

    // read data registered, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rdata <= TCP_RST_BYTE;
        end else if (i_rd) begin
            unique case (i_addr)
                TCP_OFS_CTRL: o_rdata <= ctrl;
                TCP_OFS_CA1L: o_rdata <= cap1[7:0];
                TCP_OFS_CA1H: o_rdata <= cap1[15:8];
                TCP_OFS_CAPTURE2_LOW_BYTE: o_rdata <= cap2[7:0];
                TCP_OFS_CAPTURE2_HIGH_BYTE: o_rdata <= cap2[15:8];
                TCP_OFS_T1: o_rdata <= t1;
                TCP_OFS_T2: o_rdata <= t2;
                TCP_OFS_T3L: o_rdata <= t3[7:0];
                TCP_OFS_T3H: o_rdata <= t3[15:8];
                TCP_OFS_CFG: o_rdata <= {5'h00, cfg};
                TCP_OFS_IRQ_STAT: o_rdata <= {4'h0, irq_stat};
                TCP_OFS_IRQ_MASK: o_rdata <= {4'h0, irq_mask};
                default: o_rdata <= TCP_RST_BYTE;
            endcase
        end else begin
            o_rdata <= TCP_RST_BYTE;
        end
    end

    // assertions: capture overflow and the double-buffered status
    ovf2_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cap_evt[1] && full[1] && !both_read[1] |=> master_ov[1])
        else $error("capture2 overflow not recorded");
    ovf1_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cap_evt[0] && full[0] && !both_read[0] |=> master_ov[0])
        else $error("capture1 overflow not recorded");
    cap2_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        full[1] && !both_read[1] |=> $stable(cap2))
        else $error("unread capture2 overwritten");
    cap1_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        full[0] && !both_read[0] && !i_wr |=> $stable(cap1))
        else $error("unread capture1 overwritten");
    cap2_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cap_evt[1] && !full[1] |=> cap2 == $past(t3))
        else $error("empty capture2 not loaded");
    ovf_copy_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        both_read[1] |=> ctrl[TCP_B_CA2OV] == $past(master_ov[1]))
        else $error("overflow copy wrong");
    ovf1_copy_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        both_read[0] |=> ctrl[TCP_B_CA1OV] == $past(master_ov[0]))
        else $error("capture1 overflow copy wrong");
    master_clr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        both_read[0] && !cap_evt[0] |=> !master_ov[0])
        else $error("master overflow not cleared");
    no_cap1_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !ctrl[TCP_B_SEL] && !i_wr |=> $stable(cap1))
        else $error("capture1 loaded in period mode");

    // pin steering and timer gating
    pwm_force_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl[TCP_B_PWM1] |-> !o_pwm1_shared_pin_oe_n)
        else $error("pwm1 pin not driven");
    pwm2_force_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl[TCP_B_PWM2] |-> !o_pwm2_shared_pin_oe_n)
        else $error("pwm2 pin not driven");
    pwm_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !ctrl[TCP_B_PWM2] |-> o_pwm2_shared_pin_oe_n == cfg[TCP_B_DIR3])
        else $error("pwm2 pin ignores direction");
    pwm1_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !ctrl[TCP_B_PWM1] |-> o_pwm1_shared_pin_oe_n == cfg[TCP_B_DIR2])
        else $error("pwm1 pin ignores direction");
    t2_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !ctrl[TCP_B_T2RUN] && !i_wr |=> $stable(t2))
        else $error("timer2 moved while stopped");
    t2_run_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl[TCP_B_T2RUN] && !cfg[TCP_B_CASC] && !i_wr |=> t2 == $past(t2) + 8'h01)
        else $error("timer2 not counting");
    t1_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !ctrl[TCP_B_T1RUN] && !i_wr |=> $stable(t1))
        else $error("timer1 moved while stopped");
    casc_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cfg[TCP_B_CASC] && !ctrl[TCP_B_T1RUN] && !i_wr |=> $stable(t2))
        else $error("cascade upper byte moved while stopped");
    t3_run_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl[TCP_B_T3RUN] && ctrl[TCP_B_SEL] && !i_wr |=> t3 == $past(t3) + 16'h0001)
        else $error("timer3 not counting");

    // main scenarios reached
    ov_cov: cover property (@(posedge i_ref_clk) cap_evt[1] && full[1]);
    rd_cov: cover property (@(posedge i_ref_clk) both_read[0] && master_ov[0]);
    irq_cov: cover property (@(posedge i_ref_clk) o_irq);
    casc_cov: cover property (@(posedge i_ref_clk) cfg[TCP_B_CASC] && ctrl[TCP_B_T1RUN] && t1_wrap);
    pwm_cov: cover property (@(posedge i_ref_clk) ctrl[TCP_B_PWM1] && ctrl[TCP_B_PWM2]);
endmodule

// ===== dv/tb_tcp_ctrl.sv
// Purpose: self-checking bench for the timer, capture and pwm control block
// Assumes: register port driven just after rising edges, read data one cycle later
// Notes: timers are read twice a few cycles apart to tell running from held
module tb_tcp_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import tcp_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [TCP_AW-1:0] i_addr = '0;
    logic [TCP_DW-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] cap = 2'b00;
    logic [TCP_DW-1:0] o_rdata;
    logic oe1_n, oe2_n, en1, en2, o_irq;
    logic [7:0] v0, v1;
    int mismatches = 0;
    int compares = 0;

    // pwm levels are routed outside the block, so they stay low here
    tcp_ctrl uut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cap1_pin(cap[0]),
        .i_cap2_pin(cap[1]), .i_pwm1_level(1'b0), .i_pwm2_level(1'b0),
        .o_pwm1_shared_pin_oe_n(oe1_n), .o_pwm2_shared_pin_oe_n(oe2_n),
        .o_pwm1_enable(en1), .o_pwm2_enable(en2), .o_irq(o_irq)
    );

    // 100 ns period
    always #50 i_ref_clk = ~i_ref_clk;

    // compare with case equality so an unknown never matches
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    // one-cycle write; the trailing delay lets the register update land before checks
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    // a pin pulse long enough to pass the three-flop synchroniser
    task automatic pulse(input int c);
        @(posedge i_ref_clk);
        cap[c] <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        cap[c] <= 1'b0;
        cyc(8);
    endtask

    task automatic t_reset();
        rd(TCP_OFS_CTRL, v0);
        chk(v0, TCP_RST_BYTE, "ctrl reset");
        rd(TCP_OFS_CFG, v0);
        chk(v0, {5'h00, TCP_RST_CFG}, "cfg reset");
        rd(4'hC, v0);
        chk(v0, 8'h00, "unmapped read");
        chk({6'h00, oe2_n, oe1_n}, 8'h03, "pins released after reset");
        chk({7'h00, o_irq}, 8'h00, "irq after reset");
    endtask

    // period mode: timer3 never passes the period value
    task automatic t_period();
        wr(TCP_OFS_CA1L, 8'h05);
        wr(TCP_OFS_CA1H, 8'h00);
        wr(TCP_OFS_CTRL, 8'h04);
        for (int i = 0; i < 10; i++) begin
            rd(TCP_OFS_T3L, v0);
            chk({7'h00, v0 > 8'h05}, 8'h00, "timer3 beyond period");
        end
        rd(TCP_OFS_T3H, v0);
        chk(v0, 8'h00, "timer3 high in period mode");
        // a capture1 edge in period mode must leave the period alone;
        // reading both bytes also leaves the pair tracking clean for later
        pulse(0);
        rd(TCP_OFS_CA1L, v0);
        chk(v0, 8'h05, "period low taken by capture");
        rd(TCP_OFS_CA1H, v0);
        chk(v0, 8'h00, "period high taken by capture");
    endtask

    task automatic t_runs();
        logic [3:0] ofs [3];
        ofs = '{TCP_OFS_T1, TCP_OFS_T2, TCP_OFS_T3L};
        for (int i = 0; i < 3; i++) begin
            wr(TCP_OFS_CTRL, 8'h08 | (8'h01 << i));
            rd(ofs[i], v0);
            rd(ofs[i], v1);
            chk({7'h00, v1 == v0}, 8'h00, "timer not counting");
            wr(TCP_OFS_CTRL, 8'h08);
            rd(ofs[i], v0);
            rd(ofs[i], v1);
            chk(v1, v0, "timer not held");
            // a stopped timer takes a software load unchanged
            wr(ofs[i], 8'hA5 + i[7:0]);
            rd(ofs[i], v0);
            chk(v0, 8'hA5 + i[7:0], "timer load");
        end
        wr(TCP_OFS_T3H, 8'h3C);
        rd(TCP_OFS_T3H, v0);
        chk(v0, 8'h3C, "timer3 high load");
        // cascade: the upper byte moves only while timer1 run is set
        wr(TCP_OFS_CFG, 8'h07);
        wr(TCP_OFS_CTRL, 8'h0B);
        rd(TCP_OFS_T2, v0);
        cyc(300);
        rd(TCP_OFS_T2, v1);
        chk({7'h00, v1 == v0}, 8'h00, "cascade upper byte stuck");
        wr(TCP_OFS_CTRL, 8'h0A);
        rd(TCP_OFS_T2, v0);
        cyc(300);
        rd(TCP_OFS_T2, v1);
        chk(v1, v0, "cascade upper byte moved while stopped");
        wr(TCP_OFS_CFG, 8'h06);
    endtask

    // overflow keeps the old value, reports after both bytes, then reloads
    task automatic t_capture(input int c);
        logic [3:0] lo;
        logic [3:0] hi;
        logic [7:0] ov;
        lo = (c == 1) ? TCP_OFS_CAPTURE2_LOW_BYTE : TCP_OFS_CA1L;
        hi = (c == 1) ? TCP_OFS_CAPTURE2_HIGH_BYTE : TCP_OFS_CA1H;
        ov = (c == 1) ? 8'h80 : 8'h40;
        wr(TCP_OFS_CTRL, 8'h0C);
        wr(TCP_OFS_IRQ_MASK, 8'h04 << c);
        rd(TCP_OFS_IRQ_MASK, v1);
        chk(v1, 8'h04 << c, "irq mask readback");
        pulse(c);
        rd(TCP_OFS_IRQ_STAT, v1);
        chk(v1 & (8'h01 << c), 8'h01 << c, "capture load status");
        rd(lo, v0);
        pulse(c);
        rd(lo, v1);
        chk(v1, v0, "overflow overwrote capture");
        rd(hi, v1);
        cyc(2);
        rd(TCP_OFS_CTRL, v1);
        chk(v1 & ov, ov, "overflow not reported");
        chk({7'h00, o_irq}, 8'h01, "irq for overflow");
        wr(TCP_OFS_IRQ_STAT, 8'h04 << c);
        cyc(1);
        chk({7'h00, o_irq}, 8'h00, "irq after clear");
        pulse(c);
        rd(lo, v1);
        chk({7'h00, v1 == v0}, 8'h00, "no reload after both bytes read");
        rd(hi, v1);
        cyc(2);
        rd(TCP_OFS_CTRL, v1);
        chk(v1 & ov, 8'h00, "overflow status not refreshed");
        wr(TCP_OFS_IRQ_STAT, 8'h0F);
        wr(TCP_OFS_IRQ_MASK, 8'h00);
    endtask

    task automatic t_pins();
        wr(TCP_OFS_CTRL, 8'hFF);
        rd(TCP_OFS_CTRL, v0);
        chk(v0, TCP_CTRL_WMASK, "status bits writable");
        chk({4'h0, en2, en1, oe2_n, oe1_n}, 8'h0C, "pwm forces drive");
        wr(TCP_OFS_CTRL, 8'h00);
        chk({4'h0, en2, en1, oe2_n, oe1_n}, 8'h03, "pins follow input dir");
        wr(TCP_OFS_CFG, 8'h02);
        chk({6'h00, oe2_n, oe1_n}, 8'h01, "pins follow mixed dir");
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        mismatches++;
        $display("MISMATCH t=%0t run timed out", $time);
        end_sim();
    end

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_period();
        t_runs();
        t_capture(0);
        t_capture(1);
        t_pins();
        end_sim();
    end
endmodule
